/* shared/tsiu_pkg.sv */
package tsiu_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_EDGE_SEL = 8'hbf;
	localparam logic [7:0] IDX_IRQ_REQUEST = 8'hc8;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hc9;
	localparam logic [7:0] IDX_STACK_PTR = 8'hdf;
	localparam logic [7:0] IDX_EVT_STATUS = 8'he8;
	localparam logic [7:0] IDX_EVT_MASK = 8'he9;
	localparam logic [7:0] IDX_SAVE_BUF = 8'hea;
	// source bit positions, shared by enable and request registers
	localparam int EXT_BIT = 0;
	localparam int TMR_A_BIT = 4;
	localparam int TMR_B_BIT = 5;
	localparam logic [7:0] SRC_MASK = 8'h31;
	localparam int GIE_BIT = 7;
	localparam int SP_LO = 0;
	localparam int SP_HI = 1;
	localparam int EDGE_LO = 3;
	localparam int EDGE_HI = 4;
	// event status bits
	localparam int EVT_TAKE_BIT = 0;
	localparam int EVT_WAKE_BIT = 1;
	localparam int EVT_RETURN_BIT = 2;
	localparam logic [7:0] EVT_MASK_ALL = 8'h07;
	// reset values
	localparam logic [7:0] RST_EDGE_SEL = 8'h10;
	localparam logic [7:0] RST_IRQ_REQUEST = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] RST_STACK_PTR = 8'h03;
	localparam logic [7:0] RST_EVT = 8'h00;
	// edge select codes
	localparam logic [1:0] EDGE_RSVD = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// program counter and shared vector
	localparam int PC_W = 12;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h008;
	// flag bits kept out of the save buffer (timeout, power-down)
	localparam logic [7:0] FLAG_SAVE_MASK = 8'h3f;
	typedef enum logic [0:0] {ST_RUN, ST_SLEEP} tsiu_pwr_type;
endpackage : tsiu_pkg

/* shared/tsiu_evt_if.sv */
`timescale 1ns/10ps
interface tsiu_evt_if;
	logic [1:0] edge_sel;
	logic ext_evt;
	modport trig (input edge_sel, output ext_evt);
	modport core (output edge_sel, input ext_evt);
endinterface : tsiu_evt_if

/* rtl/tsiu_ext_trigger.sv */
`timescale 1ns/10ps
module tsiu_ext_trigger
	import tsiu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ext_irq_pin,
	tsiu_evt_if.trig evt
);
	logic pin_prev_reg;
	logic pin_prev_next;
	logic evt_reg;
	logic evt_next;

	always_comb begin
		pin_prev_next = ext_irq_pin;
		case (evt.edge_sel)
			EDGE_RISE: evt_next = ext_irq_pin & ~pin_prev_reg;
			EDGE_FALL: evt_next = ~ext_irq_pin & pin_prev_reg;
			EDGE_BOTH: evt_next = ext_irq_pin ^ pin_prev_reg;
			// reserved code never triggers
			default: evt_next = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_prev_reg <= 1'b0;
			evt_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_prev_next;
			evt_reg <= evt_next;
		end
	end

	assign evt.ext_evt = evt_reg;
endmodule : tsiu_ext_trigger

/* rtl/tsiu_top.sv */
`timescale 1ns/10ps
module tsiu_top
	import tsiu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic timer_a_ovf,
	input wire logic timer_b_ovf,
	input wire logic ext_irq_pin,
	input wire logic cpu_boundary,
	input wire logic return_from_irq,
	input wire logic powerdown_enter,
	input wire logic save_req,
	input wire logic restore_req,
	input wire logic [7:0] accumulator_in,
	input wire logic [7:0] program_flags_in,
	output logic vector_load,
	output logic [PC_W-1:0] vector_pc,
	output logic stack_push,
	output logic wake_pulse,
	output logic powered_down,
	output logic restore_valid,
	output logic [7:0] accumulator_out,
	output logic [7:0] program_flags_out,
	output logic irq
);
	import tsiu_pkg::*;

	tsiu_evt_if evt_bus ();

	logic [7:0] edge_select_reg;
	logic [7:0] edge_select_next;
	logic [7:0] irq_request_reg;
	logic [7:0] irq_request_next;
	logic [7:0] irq_enable_reg;
	logic [7:0] irq_enable_next;
	logic [7:0] stack_ptr_reg;
	logic [7:0] stack_ptr_next;
	logic [7:0] evt_status_reg;
	logic [7:0] evt_status_next;
	logic [7:0] evt_mask_reg;
	logic [7:0] evt_mask_next;

	logic wr_pend_reg;
	logic wr_pend_next;
	logic [7:0] wr_idx_reg;
	logic [7:0] wr_idx_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	logic vector_load_reg;
	logic vector_load_next;
	logic wake_reg;
	logic wake_next;
	tsiu_pwr_type pwr_state_reg;
	tsiu_pwr_type pwr_state_next;

	logic [7:0] acc_buf_reg;
	logic [7:0] acc_buf_next;
	logic [7:0] flag_buf_reg;
	logic [7:0] flag_buf_next;
	logic [7:0] acc_out_reg;
	logic [7:0] acc_out_next;
	logic [7:0] flag_out_reg;
	logic [7:0] flag_out_next;
	logic restore_valid_reg;
	logic restore_valid_next;

	logic addr_phase;
	logic [7:0] addr_idx;
	logic [7:0] src_events;
	logic [7:0] wdat;
	logic global_irq_enable;
	logic any_pending;
	logic take;
	logic [7:0] evt_set;
	logic [7:0] rd_mux;

	assign evt_bus.edge_sel = edge_select_reg[EDGE_HI:EDGE_LO];

	tsiu_ext_trigger u_trigger (
		.hclk(hclk),
		.hresetn(hresetn),
		.ext_irq_pin(ext_irq_pin),
		.evt(evt_bus.trig)
	);

	// bus decode
	assign addr_phase = hsel & htrans[1] & hready;
	assign addr_idx = haddr[9:2];
	assign wdat = hwdata[7:0];

	// hardware events of the three sources, at their own bit positions
	always_comb begin
		src_events = 8'h00;
		src_events[EXT_BIT] = evt_bus.ext_evt;
		src_events[TMR_A_BIT] = timer_a_ovf;
		src_events[TMR_B_BIT] = timer_b_ovf;
	end

	assign global_irq_enable = stack_ptr_reg[GIE_BIT];
	// flags set regardless of enable, but only enabled ones vector
	assign any_pending = |(irq_request_reg & irq_enable_reg & SRC_MASK);
	// gie dropping on entry makes several pending requests one entry
	assign take = global_irq_enable & any_pending & cpu_boundary & (pwr_state_reg == ST_RUN);

	// bus slave state
	always_comb begin
		wr_pend_next = addr_phase & hwrite;
		wr_idx_next = addr_phase ? addr_idx : wr_idx_reg;
		hrdata_next = hrdata_reg;
		if (addr_phase && !hwrite) begin
			hrdata_next = {24'h00_0000, rd_mux};
		end
	end

	// read data are sampled at the address phase and held in the data phase
	always_comb begin
		case (addr_idx)
			IDX_EDGE_SEL: rd_mux = edge_select_reg & 8'h18;
			IDX_IRQ_REQUEST: rd_mux = irq_request_reg;
			IDX_IRQ_ENABLE: rd_mux = irq_enable_reg;
			IDX_STACK_PTR: rd_mux = stack_ptr_reg;
			IDX_EVT_STATUS: rd_mux = evt_status_reg;
			IDX_EVT_MASK: rd_mux = evt_mask_reg;
			IDX_SAVE_BUF: rd_mux = acc_buf_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			hrdata_reg <= hrdata_next;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// configuration, request and stack registers
	always_comb begin
		edge_select_next = edge_select_reg;
		irq_enable_next = irq_enable_reg;
		irq_request_next = irq_request_reg;
		stack_ptr_next = stack_ptr_reg;
		evt_mask_next = evt_mask_reg;
		if (wr_pend_reg) begin
			case (wr_idx_reg)
				IDX_EDGE_SEL: edge_select_next = wdat & 8'h18;
				IDX_IRQ_ENABLE: irq_enable_next = wdat & SRC_MASK;
				IDX_IRQ_REQUEST: irq_request_next = wdat & SRC_MASK;
				IDX_STACK_PTR: stack_ptr_next = wdat & 8'h83;
				IDX_EVT_MASK: evt_mask_next = wdat & EVT_MASK_ALL;
				default: ;
			endcase
		end
		// a source event in the clearing cycle is kept: set wins
		irq_request_next = irq_request_next | (src_events & SRC_MASK);
		if (take) begin
			stack_ptr_next[GIE_BIT] = 1'b0;
			stack_ptr_next[SP_HI:SP_LO] = stack_ptr_reg[SP_HI:SP_LO] + 2'h1;
		end else if (return_from_irq) begin
			stack_ptr_next[GIE_BIT] = 1'b1;
			stack_ptr_next[SP_HI:SP_LO] = stack_ptr_reg[SP_HI:SP_LO] - 2'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_select_reg <= RST_EDGE_SEL;
			irq_enable_reg <= RST_IRQ_ENABLE;
			irq_request_reg <= RST_IRQ_REQUEST;
			stack_ptr_reg <= RST_STACK_PTR;
			evt_mask_reg <= RST_EVT;
		end else begin
			edge_select_reg <= edge_select_next;
			irq_enable_reg <= irq_enable_next;
			irq_request_reg <= irq_request_next;
			stack_ptr_reg <= stack_ptr_next;
			evt_mask_reg <= evt_mask_next;
		end
	end

	// vectoring and power-down sequencing
	always_comb begin
		vector_load_next = take;
		wake_next = 1'b0;
		pwr_state_next = pwr_state_reg;
		case (pwr_state_reg)
			ST_RUN: begin
				if (powerdown_enter) begin
					pwr_state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// only the pin brings the core back to normal run
				if (evt_bus.ext_evt) begin
					pwr_state_next = ST_RUN;
					wake_next = 1'b1;
				end
			end
			default: pwr_state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_load_reg <= 1'b0;
			wake_reg <= 1'b0;
			pwr_state_reg <= ST_RUN;
		end else begin
			vector_load_reg <= vector_load_next;
			wake_reg <= wake_next;
			pwr_state_reg <= pwr_state_next;
		end
	end

	assign vector_load = vector_load_reg;
	assign vector_pc = IRQ_VECTOR;
	assign stack_push = vector_load_reg;
	assign wake_pulse = wake_reg;
	assign powered_down = (pwr_state_reg == ST_SLEEP);

	// one-level save buffer; a new save overwrites the old one
	always_comb begin
		acc_buf_next = acc_buf_reg;
		flag_buf_next = flag_buf_reg;
		acc_out_next = acc_out_reg;
		flag_out_next = flag_out_reg;
		restore_valid_next = restore_req;
		if (save_req) begin
			acc_buf_next = accumulator_in;
			flag_buf_next = program_flags_in & FLAG_SAVE_MASK;
		end
		if (restore_req) begin
			acc_out_next = acc_buf_reg;
			flag_out_next = flag_buf_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_buf_reg <= 8'h00;
			flag_buf_reg <= 8'h00;
			acc_out_reg <= 8'h00;
			flag_out_reg <= 8'h00;
			restore_valid_reg <= 1'b0;
		end else begin
			acc_buf_reg <= acc_buf_next;
			flag_buf_reg <= flag_buf_next;
			acc_out_reg <= acc_out_next;
			flag_out_reg <= flag_out_next;
			restore_valid_reg <= restore_valid_next;
		end
	end

	assign accumulator_out = acc_out_reg;
	assign program_flags_out = flag_out_reg;
	assign restore_valid = restore_valid_reg;

	// event status, write one to clear, set wins over clear
	always_comb begin
		evt_set = 8'h00;
		evt_set[EVT_TAKE_BIT] = take;
		evt_set[EVT_WAKE_BIT] = wake_next;
		evt_set[EVT_RETURN_BIT] = return_from_irq & ~take;
		evt_status_next = evt_status_reg;
		if (wr_pend_reg && (wr_idx_reg == IDX_EVT_STATUS)) begin
			evt_status_next = evt_status_reg & ~wdat;
		end
		evt_status_next = (evt_status_next | evt_set) & EVT_MASK_ALL;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_status_reg <= RST_EVT;
		end else begin
			evt_status_reg <= evt_status_next;
		end
	end

	assign irq = |(evt_status_reg & evt_mask_reg);
endmodule : tsiu_top

/* bench/tsiu_top_assertions.sv */
`timescale 1ns/10ps
module tsiu_chk
	import tsiu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cpu_boundary,
	input wire logic restore_req,
	input wire logic vector_load,
	input wire logic [PC_W-1:0] vector_pc,
	input wire logic stack_push,
	input wire logic wake_pulse,
	input wire logic powered_down,
	input wire logic restore_valid,
	input wire logic [7:0] program_flags_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_push; vector_load |-> stack_push; endproperty
	a_push: assert property (p_push) else $error("no push with vector");
	property p_vec; vector_load |-> vector_pc == 12'h008; endproperty
	a_vec: assert property (p_vec) else $error("vector address off");
	property p_one; vector_load |=> !vector_load [*2]; endproperty
	a_one: assert property (p_one) else $error("vector entry repeated");
	property p_gate; vector_load |-> $past(cpu_boundary) && !$past(powered_down); endproperty
	a_gate: assert property (p_gate) else $error("vector without boundary");
	property p_rest; restore_req |=> restore_valid; endproperty
	a_rest: assert property (p_rest) else $error("restore not answered");
	property p_flags; restore_valid |-> program_flags_out[7:6] == 2'b00; endproperty
	a_flags: assert property (p_flags) else $error("status flags restored");
	property p_wake; wake_pulse |-> $past(powered_down) && !powered_down; endproperty
	a_wake: assert property (p_wake) else $error("wake outside power-down");
	property p_leave; $fell(powered_down) |-> wake_pulse; endproperty
	a_leave: assert property (p_leave) else $error("left power-down unwoken");
endmodule : tsiu_chk
bind tsiu_top tsiu_chk chk_u (.hclk, .hresetn, .cpu_boundary, .restore_req, .vector_load,
	.vector_pc, .stack_push, .wake_pulse, .powered_down, .restore_valid, .program_flags_out);

/* bench/tsiu_cpu_model.sv */
`timescale 1ns/10ps
module tsiu_cpu_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic vector_load,
	output logic cpu_boundary,
	output logic return_from_irq
);
	logic [4:0] cnt_reg;
	logic busy_reg;
	// no boundary while the routine runs, so the service gets time to clear flags
	assign cpu_boundary = hresetn && !busy_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_reg <= 1'b0;
			cnt_reg <= 5'h00;
			return_from_irq <= 1'b0;
		end else begin
			return_from_irq <= 1'b0;
			if (vector_load) begin
				busy_reg <= 1'b1;
				cnt_reg <= 5'h00;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg + 5'h01;
				if (cnt_reg == 5'h1e) begin
					busy_reg <= 1'b0;
					return_from_irq <= 1'b1;
				end
			end
		end
	end
endmodule : tsiu_cpu_model

/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import tsiu_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, cpu_boundary, return_from_irq;
	logic timer_a_ovf = 1'b0, timer_b_ovf = 1'b0, ext_irq_pin = 1'b0;
	logic powerdown_enter = 1'b0, save_req = 1'b0, restore_req = 1'b0;
	logic [7:0] accumulator_in = 8'h00, program_flags_in = 8'h00;
	logic vector_load, stack_push, wake_pulse, powered_down, restore_valid, irq;
	logic [PC_W-1:0] vector_pc;
	logic [7:0] accumulator_out, program_flags_out, rd;
	int err_total = 0, checks = 0, cyc = 0, nvec = 0, npush = 0;
	always #25 hclk = ~hclk;
	assign hready = hreadyout;
	tsiu_top dut_u (.*);
	tsiu_cpu_model cpu_u (.*);
	task complete_run;
		$display("err_total=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	// whole run needs a few hundred cycles
	always @(posedge hclk) begin
		cyc++;
		if (vector_load === 1'b1) nvec++;
		if (stack_push === 1'b1) npush++;
		if (cyc > 20000) begin
			err_total++;
			complete_run();
		end
	end
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata[7:0];
	endtask : bus
	task rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(n, rd, e);
		chk("hresp", hresp, 1'b0);
	endtask : rchk
	task t_reset;
		rchk("edge", IDX_EDGE_SEL, 8'h10);
		rchk("req", IDX_IRQ_REQUEST, 8'h00);
		rchk("en", IDX_IRQ_ENABLE, 8'h00);
		rchk("sp", IDX_STACK_PTR, 8'h03);
		rchk("unmapped", 8'h10, 8'h00);
	endtask : t_reset
	task t_flags;
		bus(1'b1, IDX_STACK_PTR, 8'h83);
		timer_a_ovf <= 1'b1;
		@(posedge hclk);
		timer_a_ovf <= 1'b0;
		timer_b_ovf <= 1'b1;
		@(posedge hclk);
		timer_b_ovf <= 1'b0;
		repeat (20) @(posedge hclk);
		rchk("req", IDX_IRQ_REQUEST, 8'h30);
		chk("nvec", nvec, 0);
		bus(1'b1, IDX_IRQ_REQUEST, 8'h00);
		rchk("req", IDX_IRQ_REQUEST, 8'h00);
	endtask : t_flags
	task t_edges;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, IDX_EDGE_SEL, 8'(i << 3));
			ext_irq_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			rchk("rise", IDX_IRQ_REQUEST, 8'(i & 1));
			bus(1'b1, IDX_IRQ_REQUEST, 8'h00);
			ext_irq_pin <= 1'b0;
			repeat (4) @(posedge hclk);
			rchk("fall", IDX_IRQ_REQUEST, 8'(i >> 1));
			bus(1'b1, IDX_IRQ_REQUEST, 8'h00);
		end
	endtask : t_edges
	task t_take;
		bus(1'b1, IDX_STACK_PTR, 8'h03);
		bus(1'b1, IDX_IRQ_ENABLE, 8'h31);
		timer_a_ovf <= 1'b1;
		timer_b_ovf <= 1'b1;
		@(posedge hclk);
		timer_a_ovf <= 1'b0;
		timer_b_ovf <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("nvec", nvec, 0);
		bus(1'b1, IDX_STACK_PTR, 8'h83);
		repeat (10) @(posedge hclk);
		chk("nvec", nvec, 1);
		chk("npush", npush, 1);
		rchk("sp", IDX_STACK_PTR, 8'h00);
		bus(1'b1, IDX_IRQ_REQUEST, 8'h00);
		repeat (40) @(posedge hclk);
		rchk("sp", IDX_STACK_PTR, 8'h83);
		chk("nvec", nvec, 1);
		chk("irq", irq, 1'b0);
		bus(1'b1, IDX_EVT_MASK, 8'h01);
		repeat (3) @(posedge hclk);
		chk("irq", irq, 1'b1);
		bus(1'b1, IDX_EVT_STATUS, 8'h01);
		repeat (3) @(posedge hclk);
		chk("irq", irq, 1'b0);
		rchk("status", IDX_EVT_STATUS, 8'h04);
		bus(1'b1, IDX_IRQ_ENABLE, 8'h00);
	endtask : t_take
	task t_wake;
		int n;
		n = 0;
		powerdown_enter <= 1'b1;
		@(posedge hclk);
		powerdown_enter <= 1'b0;
		timer_a_ovf <= 1'b1;
		@(posedge hclk);
		timer_a_ovf <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("pd", powered_down, 1'b1);
		ext_irq_pin <= 1'b1;
		while (wake_pulse !== 1'b1 && n < 10) begin
			@(posedge hclk);
			n++;
		end
		chk("wake", wake_pulse, 1'b1);
		chk("pd", powered_down, 1'b0);
		rchk("status", IDX_EVT_STATUS, 8'h06);
		// pin flag set while asleep now vectors once its enable is on
		bus(1'b1, IDX_IRQ_ENABLE, 8'h01);
		repeat (4) @(posedge hclk);
		chk("nvec", nvec, 2);
		chk("npush", npush, 2);
		bus(1'b1, IDX_IRQ_REQUEST, 8'h00);
	endtask : t_wake
	task t_save;
		accumulator_in <= 8'ha5;
		program_flags_in <= 8'hff;
		save_req <= 1'b1;
		@(posedge hclk);
		save_req <= 1'b0;
		accumulator_in <= 8'h5a;
		program_flags_in <= 8'h00;
		restore_req <= 1'b1;
		@(posedge hclk);
		restore_req <= 1'b0;
		@(posedge hclk);
		chk("acc", accumulator_out, 8'ha5);
		chk("flags", program_flags_out, 8'h3f);
		chk("rvalid", restore_valid, 1'b1);
		rchk("buf", IDX_SAVE_BUF, 8'ha5);
	endtask : t_save
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_flags();
		t_edges();
		t_take();
		t_wake();
		t_save();
		complete_run();
	end
endmodule : tb_top
